/* dv/jsl_rx_model.sv */
// Behavioural model of the link receiver that drives SYNC and ends ILAS
`timescale 1ns/1ps
`default_nettype none

module jsl_rx_model
    import jsl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire jsl_status_s link_status,
    output var  logic        sync_n,
    output var  logic        ilas_done
);
    int dly = 20;
    int cnt = 0;

    initial sync_n = 1'h1;
    initial ilas_done = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // Request is a low level on whichever source is wired up
    task drop;
        @(negedge ref_clk);
        sync_n = 1'h0;
    endtask : drop

    // Bench calls this once CGS has had time to run
    task lift;
        @(negedge ref_clk);
        sync_n = 1'h1;
    endtask : lift

    ////////////////////////////////////////////////////////////////////////
    // ILAS finishes a fixed time after it starts
    always @(negedge ref_clk or negedge rst_n)
    begin
        cnt = (rst_n && link_status.ilas_active) ? cnt + 1 : 0;
        ilas_done <= (cnt == dly);
    end
endmodule : jsl_rx_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench for the link SYNC request and initialization control
`timescale 1ns/1ps
`default_nettype none

module tb
    import jsl_pkg::*;
;
    logic        ref_clk    = 1'h0;
    logic        rst_n      = 1'h0;
    logic        sysref     = 1'h0;
    logic        use_pair   = 1'h0;
    logic        alt        = 1'h1;
    jsl_cfg_s    cfg        = 4'h1;
    wire logic   rx_sync_n;
    wire logic   ilas_done;
    jsl_status_s link_status;
    logic        cgs_start, ilas_start, sysref_align, marker_event;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          seed       = 60032;

    always #5 ref_clk = ~ref_clk;
    // With the pair selected the single-ended pin toggles, so a leaking mux shows up
    always @(negedge ref_clk) alt <= 1'($random(seed));

    jsl_rx_model rx_u (.ref_clk(ref_clk), .rst_n(rst_n), .link_status(link_status),
        .sync_n(rx_sync_n), .ilas_done(ilas_done));
    jsl_link_init dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .single_ended_sync_request_n(use_pair ? alt : rx_sync_n),
        .differential_marker_pair(use_pair ? rx_sync_n : 1'h1), .sysref(sysref),
        .cfg(cfg), .ilas_done(ilas_done), .link_status(link_status),
        .cgs_start(cgs_start), .ilas_start(ilas_start),
        .sysref_align(sysref_align), .marker_event(marker_event));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic src_ok(input jsl_cfg_s c);
        return c.mode_8b10b && (!c.sync_source_select || c.marker_receiver_enable);
    endfunction : src_ok

    function automatic logic mark_ok(input jsl_cfg_s c);
        return c.sync_source_select && c.marker_receiver_enable && c.timestamp_enable;
    endfunction : mark_ok

    task automatic cmp_lat(input int got, input int exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_lat

    task automatic cmp_stat(input jsl_status_s got, input jsl_status_s exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_stat

    task results;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // Edge of first pulse times 16 plus pulse count, over six edges
    task automatic watch(input logic [3:0] e);
        int pos [4] = '{0, 0, 0, 0};
        int cnt [4] = '{0, 0, 0, 0};
        logic [3:0] o;
        for (int k = 1; k <= 6; k++)
        begin
            @(posedge ref_clk);
            #1;
            o = {marker_event, sysref_align, ilas_start, cgs_start};
            for (int j = 0; j < 4; j++)
                if (o[j] !== 1'h0)
                begin
                    pos[j] = (pos[j] == 0) ? k : pos[j];
                    cnt[j]++;
                end
        end
        for (int j = 0; j < 4; j++)
            cmp_lat(pos[j] * 16 + cnt[j], e[j] ? 49 : 0);
    endtask : watch

    task automatic wait_data;
        int k;
        for (k = 0; k < 40 && link_status.data_active !== 1'h1; k++)
            @(negedge ref_clk);
        cmp_stat(link_status, 3'h1);
        if (k == 40)
            results();
    endtask : wait_data

    ////////////////////////////////////////////////////////////////////////
    // First 16 passes walk every config, the rest are random accepted ones
    initial
    begin
        jsl_cfg_s c;
        logic     sr;
        int       hold;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'h1;
        for (int i = 0; i < 48; i++)
        begin
            c = (i < 16) ? jsl_cfg_s'(4'(i)) : jsl_cfg_s'(4'($random(seed)) | 4'h5);
            sr = 1'($random(seed));
            hold = $unsigned($random(seed)) % 6;
            @(negedge ref_clk);
            cfg = c;
            use_pair = c.sync_source_select;
            repeat (4) @(negedge ref_clk);
            rx_u.drop();
            sysref = sr;
            watch({1'h0, sr, 1'h0, src_ok(c)});
            if (src_ok(c) || !c.mode_8b10b)
                cmp_stat(link_status, src_ok(c) ? 3'h4 : 3'h0);
            repeat (hold) @(negedge ref_clk);
            rx_u.lift();
            sysref = 1'h0;
            watch({mark_ok(c), 1'h0, src_ok(c), 1'h0});
            if (src_ok(c))
                cmp_stat(link_status, 3'h2);
            // Odd passes skip DATA: the next pass drops again in ILAS, or turns 8b/10b off below pass 15
            if (src_ok(c) && i % 2 == 0)
                wait_data();
            $display("test %0d done", i);
        end
        results();
    end
endmodule : tb
`default_nettype wire

/* rtl/jsl_link_init.sv */
// Link SYNC request source selection and link initialization sequencing
//
// Notes on behaviour
// R1 - Single-ended SYNC request is active low; low means resynchronize.
// R2 - Single-ended input used only with source select 0 and 8b/10b mode.
// R3 - Selected request going low starts code group synchronization.
// R4 - Rising request after synchronization starts the initial lane alignment.
// R5 - Source select 1 takes the request from the differential marker pair.
// R6 - SYSREF is the timing reference for aligning the link.
// R7 - Differential pair as SYNC source is also active low.
// R8 - Differential pair usable only while its receiver enable is 1.
// R9 - Differential pair may serve as SYNC and timestamp marker at once.
// R10 - Selected request is synchronized, then edges detected, before acting.
`timescale 1ns/1ps
`default_nettype none

module jsl_link_init
    import jsl_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    input  wire logic  single_ended_sync_request_n,
    input  wire logic  differential_marker_pair,
    input  wire logic  sysref,
    input  wire jsl_cfg_s cfg,
    input  wire logic  ilas_done,
    output jsl_status_s link_status,
    output logic       cgs_start,
    output logic       ilas_start,
    output logic       sysref_align,
    output logic       marker_event
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronization

    logic [SYNC_W-1:0] sync_lvl;

    jsl_sync u_sync
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({sysref, differential_marker_pair, single_ended_sync_request_n}),
        .sync_out (sync_lvl)
    ); // [R10]

    ////////////////////////////////////////////////////////////////////////
    // Source selection

    logic sel_n_d;
    logic sel_n_q;
    logic req_fall;
    logic req_rise;

    // Disabled source reads as idle high, so a stale pin cannot start a link
    always_comb
    begin
        sel_n_d = REQ_IDLE_N;
        if (cfg.mode_8b10b)
        begin
            if (!cfg.sync_source_select)
                sel_n_d = sync_lvl[IDX_SE];                 // [R1] [R2]
            else if (cfg.marker_receiver_enable)
                sel_n_d = sync_lvl[IDX_MARKER];             // [R5] [R7] [R8]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sel_n_q <= REQ_IDLE_N;
        else
            sel_n_q <= sel_n_d;
    end

    assign req_fall = sel_n_q && !sel_n_d;                  // [R10]
    assign req_rise = !sel_n_q && sel_n_d;                  // [R10]

    ////////////////////////////////////////////////////////////////////////
    // Link state

    jsl_state_e state_q;
    jsl_state_e state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            JSL_IDLE:
                if (req_fall)
                    state_d = JSL_CGS;                      // [R3]
            JSL_CGS:
                if (req_rise)
                    state_d = JSL_ILAS;                     // [R4]
            JSL_ILAS:
                if (req_fall)
                    state_d = JSL_CGS;
                else if (ilas_done)
                    state_d = JSL_DATA;
            JSL_DATA:
                if (req_fall)
                    state_d = JSL_CGS;
            default:
                state_d = JSL_IDLE;
        endcase
        // Leaving 8b/10b mode drops the link whatever it was doing
        if (!cfg.mode_8b10b)
            state_d = JSL_IDLE;                             // [R2]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= JSL_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            link_status <= STATUS_RST;
        else
        begin
            link_status.cgs_active  <= (state_d == JSL_CGS);
            link_status.ilas_active <= (state_d == JSL_ILAS);
            link_status.data_active <= (state_d == JSL_DATA);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start pulses

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cgs_start  <= 1'h0;
            ilas_start <= 1'h0;
        end
        else
        begin
            cgs_start  <= req_fall && cfg.mode_8b10b;                       // [R3]
            ilas_start <= req_rise && (state_q == JSL_CGS) && cfg.mode_8b10b; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference and timestamp marker edges

    logic sysref_q;
    logic marker_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sysref_q     <= SYNC_RST_VAL[IDX_SYSREF];
            sysref_align <= 1'h0;
        end
        else
        begin
            sysref_q     <= sync_lvl[IDX_SYSREF];
            sysref_align <= sync_lvl[IDX_SYSREF] && !sysref_q;             // [R6]
        end
    end

    // Marker path runs regardless of source select, so the pair can serve as SYNC and timestamp marker at once
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            marker_q     <= SYNC_RST_VAL[IDX_MARKER];
            marker_event <= 1'h0;
        end
        else
        begin
            marker_q     <= sync_lvl[IDX_MARKER];
            marker_event <= sync_lvl[IDX_MARKER] && !marker_q
                            && cfg.timestamp_enable && cfg.marker_receiver_enable; // [R8] [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // A synchronized fall of the selected request while the link mode allows it
    sequence s_req_drop;
        sel_n_q && !sel_n_d && cfg.mode_8b10b;
    endsequence

    sequence s_cgs_pulse;
        cgs_start && link_status.cgs_active ##1 !cgs_start;
    endsequence

    sequence s_cgs_then_release;
        (state_q == JSL_CGS) && !sel_n_q && sel_n_d && cfg.mode_8b10b;
    endsequence

    property p_se_low_is_request;
        cfg.mode_8b10b && !cfg.sync_source_select && sel_n_q && !sync_lvl[IDX_SE]
            |=> cgs_start;
    endproperty
    a_se_low_is_request: assert property (p_se_low_is_request) // [R1] [R2]
        else $error("single-ended request not selected");

    property p_no_link_outside_8b10b;
        !cfg.mode_8b10b |=> (state_q == JSL_IDLE) && !cgs_start && !ilas_start;
    endproperty
    a_no_link_outside_8b10b: assert property (p_no_link_outside_8b10b) // [R2]
        else $error("link active outside 8b10b mode");

    property p_cgs_on_fall;
        s_req_drop |=> s_cgs_pulse;
    endproperty
    a_cgs_on_fall: assert property (p_cgs_on_fall) // [R3]
        else $error("request fall did not start cgs for one cycle");

    property p_ilas_on_release;
        s_cgs_then_release |=> ilas_start && link_status.ilas_active;
    endproperty
    a_ilas_on_release: assert property (p_ilas_on_release) // [R4]
        else $error("release after cgs did not start ilas");

    property p_marker_source;
        cfg.mode_8b10b && cfg.sync_source_select && cfg.marker_receiver_enable
            && sel_n_q && !sync_lvl[IDX_MARKER] |=> cgs_start;
    endproperty
    a_marker_source: assert property (p_marker_source) // [R5] [R7]
        else $error("marker pair not used as active-low source");

    property p_sysref_edge;
        $rose(sync_lvl[IDX_SYSREF]) |=> sysref_align ##1 !sysref_align;
    endproperty
    a_sysref_edge: assert property (p_sysref_edge) // [R6]
        else $error("sysref edge not flagged");

    // Marker pulse is registered, so the gate shows one cycle after the config
    property p_receiver_gate;
        cfg.sync_source_select && !cfg.marker_receiver_enable |-> sel_n_d ##1 !marker_event;
    endproperty
    a_receiver_gate: assert property (p_receiver_gate) // [R8]
        else $error("disabled marker receiver still in use");

    property p_marker_dual_use;
        cfg.timestamp_enable && cfg.marker_receiver_enable && $rose(sync_lvl[IDX_MARKER])
            && $stable(cfg) |=> marker_event;
    endproperty
    a_marker_dual_use: assert property (p_marker_dual_use) // [R9]
        else $error("timestamp marker lost");

    property p_cgs_needs_edge;
        $rose(cgs_start) |-> $past(sel_n_q) && !sel_n_q;
    endproperty
    a_cgs_needs_edge: assert property (p_cgs_needs_edge) // [R10]
        else $error("cgs started without a synchronized fall");

endmodule : jsl_link_init

`default_nettype wire

/* rtl/jsl_pkg.sv */
// Shared constants and types for the link SYNC request and initialization control
package jsl_pkg;

    // Synchronizer lanes: pin index inside the synchronized vector
    localparam int unsigned SYNC_W      = 3;
    localparam int unsigned IDX_SE      = 0;
    localparam int unsigned IDX_MARKER  = 1;
    localparam int unsigned IDX_SYSREF  = 2;

    // Idle levels after reset: requests are active low, reference idles low
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 3'h3;
    localparam logic              REQ_IDLE_N   = 1'h1;

    typedef enum logic [1:0]
    {
        JSL_IDLE,
        JSL_CGS,
        JSL_ILAS,
        JSL_DATA
    } jsl_state_e;

    typedef struct packed
    {
        logic sync_source_select;
        logic marker_receiver_enable;
        logic timestamp_enable;
        logic mode_8b10b;
    } jsl_cfg_s;

    typedef struct packed
    {
        logic cgs_active;
        logic ilas_active;
        logic data_active;
    } jsl_status_s;

    localparam jsl_status_s STATUS_RST = 3'h0;

endpackage : jsl_pkg

/* rtl/jsl_sync.sv */
// Two-flop synchronizers for the asynchronous request, marker and reference pins
`timescale 1ns/1ps
`default_nettype none

module jsl_sync
    import jsl_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [SYNC_W-1:0] async_in,
    output logic      [SYNC_W-1:0] sync_out
);

    genvar g;

    generate
        for (g = 0; g < SYNC_W; g++)
        begin : g_bit
            logic meta_q;

            // First stage feeds only the second stage
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q      <= SYNC_RST_VAL[g];
                    sync_out[g] <= SYNC_RST_VAL[g];
                end
                else
                begin
                    meta_q      <= async_in[g];
                    sync_out[g] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : jsl_sync

`default_nettype wire
